// ---- dv/cgpd_asserts.sv ----
// Concurrent checks on the ports of the clock controller
`timescale 1ns/1ps
`default_nettype none
module cgpd_asserts
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_rdata,
   input wire logic wait_for_interrupt_instr,
   input wire logic wakeup_irq,
   input wire logic tick_use_cpu_clk,
   input wire logic hxt_enable,
   input wire logic lxt_enable,
   input wire logic hirc_enable,
   input wire logic lirc_enable,
   input wire logic pll_enable,
   input wire logic power_down,
   input wire logic system_clock,
   input wire logic tick_clock
);
   logic [7:0] pd_cycles;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles spent in power-down; a switch may need half a slow period to park low
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pd_cycles <= 8'h00;
      else if (!power_down)
         pd_cycles <= 8'h00;
      else if (pd_cycles != 8'hff)
         pd_cycles <= pd_cycles + 8'h01;
   end

   // Steady power-down and a wake-up pin held long enough to pass the synchroniser
   sequence s_pd_steady;
      power_down [*2];
   endsequence
   sequence s_wake_held;
      wakeup_irq [*6];
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   a_pd_entry: assert property ($rose(power_down) |-> $past(wait_for_interrupt_instr))
      else $error("power-down entered without a sleep instruction");
   a_wake_exit: assert property ($fell(power_down) |-> $past(wakeup_irq, 4) && $past(wakeup_irq, 5))
      else $error("power-down left without a wake-up");
   a_wake_bound: assert property (s_wake_held |-> !power_down)
      else $error("power-down kept despite a held wake-up");
   a_hf_off: assert property (s_pd_steady |-> !hxt_enable && !hirc_enable && !pll_enable)
      else $error("fast source still enabled in power-down");
   a_sys_parked: assert property (pd_cycles > 8'h64 |-> !system_clock && !tick_clock)
      else $error("system or tick clock running in power-down");
   a_lf_keep: assert property (power_down && $past(power_down) && !$past(reg_wr, 2)
      |-> $stable(lxt_enable) && $stable(lirc_enable))
      else $error("slow source enable changed by power-down");
   a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside the answer cycle");
   a_tick_cpu: assert property (tick_use_cpu_clk && $past(tick_use_cpu_clk) && !power_down && !$past(power_down)
      |-> tick_clock == $past(system_clock))
      else $error("tick clock does not follow the processor clock");
endmodule
`default_nettype wire

// ---- dv/cgpd_far_model.sv ----
// Far side of the clock controller: oscillator pins and the core's sleep instruction
`timescale 1ns/1ps
`default_nettype none
module cgpd_far_model
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sleep_go,
   input wire logic hxt_enable,
   input wire logic lxt_enable,
   input wire logic hirc_enable,
   input wire logic lirc_enable,
   input wire logic pll_enable,
   input wire logic pll_ref_sel,
   output logic wait_for_interrupt_instr,
   output logic osc_hxt,
   output logic osc_lxt,
   output logic osc_hirc,
   output logic osc_lirc,
   output logic pll_output
);
   logic [6:0] ticks;

   ////////////////////////////////////////////////////////////////////////////////
   // Stopped oscillators park low like a dead crystal; the PLL also needs its reference alive
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ticks <= 7'h00;
         {osc_hxt, osc_lxt, osc_hirc, osc_lirc, pll_output} <= 5'h00;
         wait_for_interrupt_instr <= 1'b0;
      end
      else
      begin
         ticks <= ticks + 7'h01;
         osc_hxt <= hxt_enable & ticks[2];
         pll_output <= pll_enable & (pll_ref_sel ? hirc_enable : hxt_enable) & ticks[3];
         osc_hirc <= hirc_enable & ticks[4];
         osc_lirc <= lirc_enable & ticks[5];
         osc_lxt <= lxt_enable & ticks[6];
         wait_for_interrupt_instr <= sleep_go;
      end
   end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench of the clock controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, sys_rst, reg_wr, reg_rd, wakeup_irq, tick_use_cpu_clk, sleep_go, wait_for_interrupt_instr;
   logic osc_hxt, osc_lxt, osc_hirc, osc_lirc, pll_output, hxt_enable, lxt_enable, hirc_enable, lirc_enable;
   logic pll_enable, pll_ref_sel, power_down, system_clock, tick_clock, divided_clock_out;
   logic rd_seen = 1'b0;
   logic [3:0] periph_clock;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [31:0] exp_q[$];
   logic [7:0] ofs[9] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h08};
   logic [31:0] rst[9] = '{32'h0c, 32'h01, 32'h24, 32'h44, 32'h00, 32'h444, 32'h00, 32'h00, 32'h00};
   int err_total = 0;
   int samples_checked = 0;
   int cnt[7];
   int e;
   int src_e[8] = '{128, 8, 64, 16, 32, 0, 0, 0};

   cgpd_clock_ctrl dut (.*);
   cgpd_far_model far (.*);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      samples_checked++;
      if (seen !== expv)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Register port: one-cycle strobes, an idle cycle after each so no strobe is set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] expv);
      exp_q.push_back(expv);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic pulse_sleep();
      sleep_go <= 1'b1;
      @(posedge clk);
      sleep_go <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // Rising edges of every clock output over n cycles, so one window serves all
   task automatic sample(input int n);
      logic [6:0] prev, cur;
      cnt = '{default: 0};
      prev = 7'h00;
      repeat (n)
      begin
         @(posedge clk);
         cur = {divided_clock_out, periph_clock, tick_clock, system_clock};
         for (int i = 0; i < 7; i++)
            if (cur[i] === 1'b1 && prev[i] !== 1'b1)
               cnt[i]++;
         prev = cur;
      end
   endtask

   // Window edges may cut one period either way
   task automatic rate(input int i, input int ex);
      check(32'((cnt[i] >= ex - 1 && cnt[i] <= ex + 1) ? ex : cnt[i]), 32'(ex));
   endtask

   task automatic wait_pd(input logic lvl);
      int k;
      k = 0;
      while (power_down !== lvl && k < 40)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 40)
      begin
         err_total++;
         end_of_test();
      end
   endtask

   // Read answers are taken one cycle after the strobe, oldest expectation first
   always @(posedge clk)
   begin
      if (rd_seen)
         check(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, wakeup_irq, tick_use_cpu_clk, sleep_go} = 5'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      v = $urandom(32'h907a);
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // Reset values, then an unmapped offset that reads zero
      foreach (ofs[i])
         rd(ofs[i], rst[i]);
      wr(8'h00, 32'h0f);
      wr(8'h04, 32'h1f);
      v = 32'((($urandom % 5) << 4) | ($urandom % 5));
      wr(8'h14, v);
      rd(8'h14, v);
      for (int r = 1; r >= 0; r--)
      begin
         wr(8'h20, 32'(r));
         @(posedge clk);
         check({31'h0, pll_ref_sel}, 32'(r));
      end
      // Every system code, the three unused ones giving a stopped clock; the tick switch gets the five used codes
      for (int s = 0; s < 8; s++)
      begin
         wr(8'h10, 32'((((s + 2) % 5) << 3) | s));
         repeat (300) @(posedge clk);
         sample(1024);
         rate(0, src_e[s]);
         rate(1, src_e[(s + 2) % 5]);
      end
      // Processor clock as tick source while the system clock is halved
      wr(8'h10, 32'h08);
      tick_use_cpu_clk <= 1'b1;
      wr(8'h18, 32'h01);
      repeat (300) @(posedge clk);
      sample(1024);
      rate(0, 64);
      rate(1, 64);
      tick_use_cpu_clk <= 1'b0;
      wr(8'h18, 32'h00);
      // Divider taps, then a stop that must park the output low
      wr(8'h1c, 32'h043);
      for (int k = 0; k < 2; k++)
      begin
         e = k ? int'($urandom % 3) : 0;
         wr(8'h24, 32'(16 + e));
         repeat (100) @(posedge clk);
         sample(1024);
         rate(6, 128 >> (e + 1));
      end
      wr(8'h24, 32'(e));
      repeat (100) @(posedge clk);
      sample(512);
      check(32'(cnt[6]), 32'h0);
      check({31'h0, divided_clock_out}, 32'h0);
      // Gates off: every gated clock parks low while the ungated tick clock runs on
      wr(8'h04, 32'h00);
      repeat (150) @(posedge clk);
      sample(512);
      check(32'(cnt[0] + cnt[2] + cnt[3] + cnt[4] + cnt[5]), 32'h0);
      rate(1, 4);
      wr(8'h04, 32'h1f);
      // A sleep instruction alone is ignored; with the request it enters power-down
      wr(8'h14, 32'h01);
      pulse_sleep();
      check({31'h0, power_down}, 32'h0);
      wr(8'h00, 32'h8f);
      pulse_sleep();
      wait_pd(1'b1);
      repeat (150) @(posedge clk);
      sample(1024);
      check({27'h0, pll_enable, hxt_enable, hirc_enable, lxt_enable, lirc_enable}, 32'h3);
      check(32'(cnt[0] + cnt[1]), 32'h0);
      rate(2, 8);
      rate(3, 0);
      rate(4, 16);
      rate(5, 0);
      // Wake-up clears the request, so a bare sleep instruction no longer enters
      wakeup_irq <= 1'b1;
      wait_pd(1'b0);
      repeat (4) @(posedge clk);
      wakeup_irq <= 1'b0;
      rd(8'h00, 32'h0f);
      pulse_sleep();
      check({31'h0, power_down}, 32'h0);
      end_of_test();
   end
endmodule

bind cgpd_clock_ctrl cgpd_asserts chk (.*);
`default_nettype wire

// ---- rtl/cgpd_clk_switch.sv ----
// Glitch-free clock source switch with gating
`timescale 1ns/1ps
`default_nettype none
module cgpd_clk_switch
   import cgpd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] src,
   input wire logic [2:0] sel,
   input wire logic enable,
   output logic clk_out
);

   logic [2:0] cur_sel;
   logic active;
   logic [2:0] next_sel;
   logic next_active;
   logic want;

   ////////////////////////////////////////////////////////////////////////////
   // Leave a source only while the output is low, join the new one only
   // while it is low, so no shortened pulse ever appears
   always_comb
   begin
      want = enable && (sel == cur_sel);
      next_sel = cur_sel;
      next_active = active;
      if (!want)
      begin
         if (!clk_out)
         begin
            next_active = 1'b0;
            next_sel = sel;
         end
      end
      else if (!active && !cgpd_pick(src, cur_sel))
         next_active = 1'b1;
   end

   // Selection state
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cur_sel <= 3'h4;
         active <= 1'b0;
      end
      else
      begin
         cur_sel <= next_sel;
         active <= next_active;
      end
   end

   // Output follows the chosen source only while active
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         clk_out <= 1'b0;
      else
         clk_out <= next_active && cgpd_pick(src, next_sel);
   end

endmodule
`default_nettype wire

// ---- rtl/cgpd_clock_ctrl.sv ----
// Clock controller: source selection, gating, power-down sequencing, divider
`timescale 1ns/1ps
`default_nettype none
`include "cgpd_regs.svh"
module cgpd_clock_ctrl
   import cgpd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic wait_for_interrupt_instr,
   input wire logic wakeup_irq,
   input wire logic tick_use_cpu_clk,
   input wire logic osc_hxt,
   input wire logic osc_lxt,
   input wire logic osc_hirc,
   input wire logic osc_lirc,
   input wire logic pll_output,
   output logic hxt_enable,
   output logic lxt_enable,
   output logic hirc_enable,
   output logic lirc_enable,
   output logic pll_enable,
   output logic pll_ref_sel,
   output logic power_down,
   output logic system_clock,
   output logic tick_clock,
   output logic [3:0] periph_clock,
   output logic divided_clock_out
);

   // Switch instance indices
   localparam int SW_SYS = 0;
   localparam int SW_TICK = 1;
   localparam int SW_P0 = 2;
   localparam int SW_FDIV = 6;
   localparam int SW_NUM = 7;

   logic [31:0] pwr_ctrl;
   logic [4:0] gate_ctrl;
   logic [5:0] clock_select_reg0;
   logic [7:0] peripheral_select_reg1;
   logic [10:0] peripheral_select_reg2;
   logic [3:0] clkdiv;
   logic pll_ctrl;
   logic [4:0] freq_divider_ctrl;
   logic [5:0] sync1, sync2, sync3;
   logic [5:0] pin_level;
   logic [4:0] src;
   logic wake;
   cgpd_pd_state_t pd_state;
   cgpd_pd_state_t next_pd_state;
   logic [2:0] sw_sel [SW_NUM];
   logic [SW_NUM-1:0] sw_en;
   logic [SW_NUM-1:0] sw_out;
   logic sys_prev, fdiv_prev;
   logic [3:0] hdiv_cnt, next_hdiv_cnt;
   logic [15:0] fdiv_chain;
   logic fdiv_running;
   logic [3:0] divider_tap_select;
   logic wr_hit_pwr;
   logic [31:0] read_value;

   ////////////////////////////////////////////////////////////////////////////
   // Pin inputs: three flops, a change counts once stages two and three agree
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
         pin_level <= 6'h00;
      end
      else
      begin
         sync1 <= {wakeup_irq, osc_hirc, osc_lirc, pll_output, osc_lxt, osc_hxt};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 6; i++)
            if (sync2[i] == sync3[i])
               pin_level[i] <= sync3[i];
      end
   end

   // Five generator sources in select-code order
   assign src = pin_level[4:0];
   assign wake = pin_level[5];

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_comb
   begin
      next_pd_state = pd_state;
      unique case (pd_state)
         CGPD_ST_RUN:
            if (pwr_ctrl[`CGPD_PWR_REQ] && wait_for_interrupt_instr)
               next_pd_state = CGPD_ST_DOWN;
         CGPD_ST_DOWN:
            if (wake)
               next_pd_state = CGPD_ST_RUN;
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pd_state <= CGPD_ST_RUN;
      else
         pd_state <= next_pd_state;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   assign wr_hit_pwr = reg_wr && (reg_addr == `CGPD_OFS_PWR);

   // Power control; a software write in the wake-up cycle wins over the clear
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pwr_ctrl <= `CGPD_RST_PWR;
      else if (wr_hit_pwr)
         pwr_ctrl <= reg_wdata & `CGPD_PWR_MASK;
      else if (pd_state == CGPD_ST_DOWN && wake)
         pwr_ctrl[`CGPD_PWR_REQ] <= 1'b0;
   end

   // Gating, selects, dividers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gate_ctrl <= 5'(`CGPD_RST_GATE);
         clock_select_reg0 <= 6'(`CGPD_RST_SEL0);
         peripheral_select_reg1 <= 8'(`CGPD_RST_SEL1);
         peripheral_select_reg2 <= 11'(`CGPD_RST_SEL2);
         clkdiv <= 4'(`CGPD_RST_CLKDIV);
         pll_ctrl <= 1'(`CGPD_RST_PLL);
         freq_divider_ctrl <= 5'(`CGPD_RST_FREQ_DIVIDER_CTRL);
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `CGPD_OFS_GATE: gate_ctrl <= reg_wdata[4:0];
            `CGPD_OFS_SEL0: clock_select_reg0 <= reg_wdata[5:0];
            `CGPD_OFS_SEL1: peripheral_select_reg1 <= reg_wdata[7:0];
            `CGPD_OFS_SEL2: peripheral_select_reg2 <= reg_wdata[10:0];
            `CGPD_OFS_CLKDIV: clkdiv <= reg_wdata[3:0];
            `CGPD_OFS_PLL: pll_ctrl <= reg_wdata[0];
            `CGPD_OFS_FREQ_DIVIDER_CTRL: freq_divider_ctrl <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: data stand for one cycle after the strobe, else zero
   always_comb
   begin
      unique case (reg_addr)
         `CGPD_OFS_PWR: read_value = pwr_ctrl;
         `CGPD_OFS_GATE: read_value = {27'h0, gate_ctrl};
         `CGPD_OFS_STATUS: read_value = {26'h0, pd_state == CGPD_ST_DOWN, src};
         `CGPD_OFS_SEL0: read_value = {26'h0, clock_select_reg0};
         `CGPD_OFS_SEL1: read_value = {24'h0, peripheral_select_reg1};
         `CGPD_OFS_CLKDIV: read_value = {28'h0, clkdiv};
         `CGPD_OFS_SEL2: read_value = {21'h0, peripheral_select_reg2};
         `CGPD_OFS_PLL: read_value = {31'h0, pll_ctrl};
         `CGPD_OFS_FREQ_DIVIDER_CTRL: read_value = {27'h0, freq_divider_ctrl};
         default: read_value = 32'h0000_0000;
      endcase
   end

   // Registered read data
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0000_0000;
      else
         reg_rdata <= reg_rd ? read_value : 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator and PLL controls; low-speed sources ignore power-down
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hxt_enable <= 1'b0;
         hirc_enable <= 1'b0;
         lxt_enable <= 1'b0;
         lirc_enable <= 1'b0;
         pll_enable <= 1'b0;
         pll_ref_sel <= 1'b0;
         power_down <= 1'b0;
      end
      else
      begin
         hxt_enable <= pwr_ctrl[`CGPD_PWR_HXT_EN] && next_pd_state == CGPD_ST_RUN;
         hirc_enable <= pwr_ctrl[`CGPD_PWR_HIRC_EN] && next_pd_state == CGPD_ST_RUN;
         lxt_enable <= pwr_ctrl[`CGPD_PWR_LXT_EN];
         lirc_enable <= pwr_ctrl[`CGPD_PWR_LIRC_EN];
         pll_enable <= next_pd_state == CGPD_ST_RUN;
         pll_ref_sel <= pll_ctrl;
         power_down <= next_pd_state == CGPD_ST_DOWN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Select fields and enables of every switch
   always_comb
   begin
      sw_sel[SW_SYS] = clock_select_reg0[`CGPD_SEL0_SYS_LSB +: 3];
      sw_sel[SW_TICK] = clock_select_reg0[`CGPD_SEL0_TICK_LSB +: 3];
      sw_sel[SW_P0] = peripheral_select_reg1[`CGPD_SELP_A_LSB +: 3];
      sw_sel[SW_P0 + 1] = peripheral_select_reg1[`CGPD_SELP_B_LSB +: 3];
      sw_sel[SW_P0 + 2] = peripheral_select_reg2[`CGPD_SELP_A_LSB +: 3];
      sw_sel[SW_P0 + 3] = peripheral_select_reg2[`CGPD_SELP_B_LSB +: 3];
      sw_sel[SW_FDIV] = peripheral_select_reg2[`CGPD_SEL2_FDIV_LSB +: 3];
      // System and tick clocks stop outright in power-down
      sw_en[SW_SYS] = gate_ctrl[`CGPD_GATE_SYS] && pd_state == CGPD_ST_RUN;
      sw_en[SW_TICK] = !tick_use_cpu_clk && pd_state == CGPD_ST_RUN;
      for (int i = 0; i < 4; i++)
         sw_en[SW_P0 + i] = gate_ctrl[`CGPD_GATE_P0 + i]
            && (pd_state == CGPD_ST_RUN || cgpd_is_low_speed(sw_sel[SW_P0 + i]));
      sw_en[SW_FDIV] = pd_state == CGPD_ST_RUN || cgpd_is_low_speed(sw_sel[SW_FDIV]);
   end

   // One glitch-free switch per clock
   for (genvar g = 0; g < SW_NUM; g++)
   begin : g_sw
      cgpd_clk_switch u_sw (
         .clk(clk),
         .sys_rst(sys_rst),
         .src(src),
         .sel(sw_sel[g]),
         .enable(sw_en[g]),
         .clk_out(sw_out[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // System clock divider: one high phase every clkdiv+1 source periods
   always_comb
   begin
      next_hdiv_cnt = hdiv_cnt;
      if (sw_out[SW_SYS] && !sys_prev)
         next_hdiv_cnt = (hdiv_cnt >= clkdiv) ? 4'h0 : hdiv_cnt + 4'h1;
   end

   // Divider state and output; count advances only on source rise
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sys_prev <= 1'b0;
         hdiv_cnt <= 4'h0;
         system_clock <= 1'b0;
      end
      else
      begin
         sys_prev <= sw_out[SW_SYS];
         hdiv_cnt <= next_hdiv_cnt;
         system_clock <= sw_out[SW_SYS] && next_hdiv_cnt == 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tick and peripheral clock outputs
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tick_clock <= 1'b0;
         periph_clock <= 4'h0;
      end
      else
      begin
         tick_clock <= tick_use_cpu_clk ? system_clock : sw_out[SW_TICK];
         periph_clock <= sw_out[SW_P0 +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-of-two divider: sixteen chained halving stages, one tapped
   assign divider_tap_select = freq_divider_ctrl[3:0];

   // Chain advances on divider source rise; a stop waits for a low tap
   // Stage N toggles every 2^N input rises, so divided_clock_out = Fin / 2^(N+1)
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         fdiv_prev <= 1'b0;
         fdiv_chain <= 16'h0000;
         fdiv_running <= 1'b0;
         divided_clock_out <= 1'b0;
      end
      else
      begin
         fdiv_prev <= sw_out[SW_FDIV];
         if (freq_divider_ctrl[`CGPD_FDIV_RUN])
            fdiv_running <= 1'b1;
         else if (!fdiv_chain[divider_tap_select])
            fdiv_running <= 1'b0;
         if (fdiv_running && sw_out[SW_FDIV] && !fdiv_prev)
            fdiv_chain <= fdiv_chain + 16'h0001;
         divided_clock_out <= fdiv_chain[divider_tap_select];
      end
   end

endmodule
`default_nettype wire

// ---- rtl/cgpd_pkg.sv ----
// Types and helper functions of the clock controller
`default_nettype none
package cgpd_pkg;

   // Clock source codes of every 3-bit select field
   typedef enum logic [2:0] {
      CGPD_SRC_HXT = 3'b000,
      CGPD_SRC_LXT = 3'b001,
      CGPD_SRC_PLL = 3'b010,
      CGPD_SRC_LIRC = 3'b011,
      CGPD_SRC_HIRC = 3'b100
   } cgpd_src_t;

   // Power state
   typedef enum logic {
      CGPD_ST_RUN = 1'b0,
      CGPD_ST_DOWN = 1'b1
   } cgpd_pd_state_t;

   // Level of the selected source; unused codes give a still-low clock
   function automatic logic cgpd_pick(input logic [4:0] src, input logic [2:0] sel);
      logic r;
      r = 1'b0;
      if (sel <= 3'h4)
         r = src[sel];
      return r;
   endfunction

   // True for the two sources that keep running in power-down
   function automatic logic cgpd_is_low_speed(input logic [2:0] sel);
      return (sel == CGPD_SRC_LXT) || (sel == CGPD_SRC_LIRC);
   endfunction

endpackage
`default_nettype wire

// ---- rtl/cgpd_regs.svh ----
// Register offsets, field positions and reset values of the clock controller
`ifndef CGPD_REGS_SVH
`define CGPD_REGS_SVH

// Byte offsets on the register port
`define CGPD_OFS_PWR 8'h00
`define CGPD_OFS_GATE 8'h04
`define CGPD_OFS_STATUS 8'h0c
`define CGPD_OFS_SEL0 8'h10
`define CGPD_OFS_SEL1 8'h14
`define CGPD_OFS_CLKDIV 8'h18
`define CGPD_OFS_SEL2 8'h1c
`define CGPD_OFS_PLL 8'h20
`define CGPD_OFS_FREQ_DIVIDER_CTRL 8'h24

// Power control fields
`define CGPD_PWR_HXT_EN 0
`define CGPD_PWR_LXT_EN 1
`define CGPD_PWR_HIRC_EN 2
`define CGPD_PWR_LIRC_EN 3
`define CGPD_PWR_REQ 7
`define CGPD_PWR_MASK 32'h0000_008f

// Select fields: system [2:0], tick [5:3]; peripheral fields 4 bits apart
`define CGPD_SEL0_SYS_LSB 0
`define CGPD_SEL0_TICK_LSB 3
`define CGPD_SELP_A_LSB 0
`define CGPD_SELP_B_LSB 4
`define CGPD_SEL2_FDIV_LSB 8

// Gate bits: [0] system clock, [4:1] peripheral clocks
`define CGPD_GATE_SYS 0
`define CGPD_GATE_P0 1

// Divider control: tap select [3:0], run [4]
`define CGPD_FDIV_RUN 4

// Reset values
`define CGPD_RST_PWR 32'h0000_000c
`define CGPD_RST_GATE 32'h0000_0001
`define CGPD_RST_SEL0 32'h0000_0024
`define CGPD_RST_SEL1 32'h0000_0044
`define CGPD_RST_SEL2 32'h0000_0444
`define CGPD_RST_CLKDIV 32'h0000_0000
`define CGPD_RST_PLL 32'h0000_0000
`define CGPD_RST_FREQ_DIVIDER_CTRL 32'h0000_0000

`endif
